/* mhbp_pkg.sv */
// constants, types and layouts of the multimode host bus port
package mhbp_pkg;
    localparam int          ADDR_W        = 5;
    localparam int          DATA_W        = 8;
    localparam logic [2:0]  SEL_CS_TIMED  = 3'h4;
    localparam logic [2:0]  SEL_SERIAL    = 3'h5;
    localparam int          ACK_MIN_CYC   = 2;
    localparam int          CLK_NS        = 10;
    localparam int          SDO_RELEASE_NS  = 120;
    localparam int          SDO_RELEASE_CYC = SDO_RELEASE_NS / CLK_NS;
    localparam int          SYNC_LAT_CYC  = 5;
    localparam int          DATA_PIPE     = 4;
    localparam int          RW_BITS       = 1;
    localparam int          HDR_BITS      = RW_BITS + ADDR_W;
    localparam int          FRAME_BITS    = HDR_BITS + DATA_W;
    localparam logic        RW_READ       = 1'b1;
    // synchroniser lanes
    localparam int          SYNC_W        = 6;
    localparam int          IDX_CS        = 0;
    localparam int          IDX_RD        = 1;
    localparam int          IDX_WR        = 2;
    localparam int          IDX_SCLK      = 3;
    localparam int          IDX_SDI       = 4;
    localparam int          IDX_EDGE      = 5;
    localparam logic [SYNC_W-1:0] SYNC_RST = 6'h07;

    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } mhbp_req_s;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WAIT = 3'b010,
        ST_DONE = 3'b100
    } mhbp_state_e;
endpackage

/* mhbp_sync.sv */
// three-flop synchroniser with agreement filter, one lane per bit
`timescale 1ns/10ps
module mhbp_sync #(
    parameter int              W       = 1,
    parameter logic [W-1:0]    RST_VAL = '0
) (
    input  wire logic          sys_clk_in,   // system clock
    input  wire logic          rst_n_in,     // synchronous reset, active low
    input  wire logic [W-1:0]  async_in,     // raw pins
    output logic      [W-1:0]  filt_out      // filtered level
);
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;

    // s1 feeds s2 only; a change counts once s2 and s3 agree
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            s1_reg   <= RST_VAL;
            s2_reg   <= RST_VAL;
            s3_reg   <= RST_VAL;
            filt_out <= RST_VAL;
        end else begin
            s1_reg <= async_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            for (int i = 0; i < W; i++) begin
                if (s2_reg[i] == s3_reg[i]) begin
                    filt_out[i] <= s3_reg[i];
                end
            end
        end
    end
endmodule

/* mhbp_top.sv */
// multimode host bus port: strobe, chip-select timed and serial slave
`timescale 1ns/10ps
module mhbp_top (
    input  wire logic                        sys_clk_in,          // system clock, 100 MHz
    input  wire logic                        rst_n_in,            // synchronous reset, active low
    input  wire logic [2:0]                  host_port_select_in, // port style strap
    input  wire logic                        chip_select_n_in,    // chip select, active low
    input  wire logic                        read_strobe_n_in,    // read strobe, active low
    input  wire logic                        write_strobe_n_in,   // write strobe or direction level
    input  wire logic                        latch_enable_in,     // serial clock in serial mode
    input  wire logic [mhbp_pkg::ADDR_W-1:0] addr_in,             // address; bits 1,0 edge sel, serial in
    input  wire logic [mhbp_pkg::DATA_W-1:0] data_in,             // data bus input
    output logic      [mhbp_pkg::DATA_W-1:0] data_out,            // data bus output, bit 0 serial out
    output logic      [mhbp_pkg::DATA_W-1:0] data_oe_n_out,       // data bus enable, low drives
    output logic                             ready_out,           // ready or acknowledge level
    output logic                             ready_oe_n_out,      // ready enable, low drives
    output mhbp_pkg::mhbp_req_s              req_out,             // register access request
    input  wire logic [mhbp_pkg::DATA_W-1:0] rdata_in             // read data, cycle after req rd
);
    localparam int CNT_W = $clog2(mhbp_pkg::FRAME_BITS + 1);
    localparam int ACK_W = $clog2(mhbp_pkg::ACK_MIN_CYC + 1);

    // the serial output must float in time, and the hold counter needs something to count
    if (mhbp_pkg::SYNC_LAT_CYC > mhbp_pkg::SDO_RELEASE_CYC) begin : g_lat_chk
        $error("synchroniser latency exceeds serial output release time");
    end
    if (mhbp_pkg::ACK_MIN_CYC < 1) begin : g_ack_chk
        $error("minimum ready hold must be at least one clock");
    end

    logic [mhbp_pkg::SYNC_W-1:0] raw;
    logic [mhbp_pkg::SYNC_W-1:0] filt;
    logic [mhbp_pkg::SYNC_W-1:0] filt_d_reg;

    assign raw[mhbp_pkg::IDX_CS]   = chip_select_n_in;
    assign raw[mhbp_pkg::IDX_RD]   = read_strobe_n_in;
    assign raw[mhbp_pkg::IDX_WR]   = write_strobe_n_in;
    assign raw[mhbp_pkg::IDX_SCLK] = latch_enable_in;
    assign raw[mhbp_pkg::IDX_SDI]  = addr_in[0];
    assign raw[mhbp_pkg::IDX_EDGE] = addr_in[1];

    mhbp_sync #(
        .W       (mhbp_pkg::SYNC_W),
        .RST_VAL (mhbp_pkg::SYNC_RST)
    ) u_sync (
        .sys_clk_in (sys_clk_in),
        .rst_n_in   (rst_n_in),
        .async_in   (raw),
        .filt_out   (filt)
    );

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            filt_d_reg <= mhbp_pkg::SYNC_RST;
        end else begin
            filt_d_reg <= filt;
        end
    end

    wire cs_n     = filt[mhbp_pkg::IDX_CS];
    wire cs_fall  = filt_d_reg[mhbp_pkg::IDX_CS] & ~cs_n;
    wire cs_rise  = ~filt_d_reg[mhbp_pkg::IDX_CS] & cs_n;
    wire rd_fall  = filt_d_reg[mhbp_pkg::IDX_RD] & ~filt[mhbp_pkg::IDX_RD];
    wire rd_rise  = ~filt_d_reg[mhbp_pkg::IDX_RD] & filt[mhbp_pkg::IDX_RD];
    wire wr_fall  = filt_d_reg[mhbp_pkg::IDX_WR] & ~filt[mhbp_pkg::IDX_WR];
    wire wr_rise  = ~filt_d_reg[mhbp_pkg::IDX_WR] & filt[mhbp_pkg::IDX_WR];
    wire sck_rise = ~filt_d_reg[mhbp_pkg::IDX_SCLK] & filt[mhbp_pkg::IDX_SCLK];
    wire sck_fall = filt_d_reg[mhbp_pkg::IDX_SCLK] & ~filt[mhbp_pkg::IDX_SCLK];

    // strap taken once after reset release; changing it live is not supported
    logic [2:0] sel_reg;
    logic       sel_done_reg;
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            sel_reg      <= 3'h0;
            sel_done_reg <= 1'b0;
        end else if (!sel_done_reg) begin
            sel_reg      <= host_port_select_in;
            sel_done_reg <= 1'b1;
        end
    end

    wire mode_cs     = sel_done_reg && (sel_reg == mhbp_pkg::SEL_CS_TIMED);
    wire mode_serial = sel_done_reg && (sel_reg == mhbp_pkg::SEL_SERIAL);
    wire mode_strobe = sel_done_reg && !mode_cs && !mode_serial;

    // data delay line lines raw bus samples up with the synchroniser latency
    logic [mhbp_pkg::DATA_W-1:0] dpipe_reg [mhbp_pkg::DATA_PIPE];
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            for (int i = 0; i < mhbp_pkg::DATA_PIPE; i++) begin
                dpipe_reg[i] <= '0;
            end
        end else begin
            dpipe_reg[0] <= data_in;
            for (int i = 1; i < mhbp_pkg::DATA_PIPE; i++) begin
                dpipe_reg[i] <= dpipe_reg[i-1];
            end
        end
    end

    // one sequencer serves both parallel styles; the start, direction and end events and the ready polarity differ
    mhbp_pkg::mhbp_state_e           st_reg;         // parallel cycle state
    logic                            dir_rd_reg;     // access in progress is a read
    logic [ACK_W-1:0]                hold_cnt_reg;   // clocks spent waiting
    logic                            rd_pend_reg;    // read data arrives this cycle
    logic [CNT_W-1:0]                bit_cnt_reg;    // serial bits taken so far
    logic [mhbp_pkg::FRAME_BITS-1:0] sin_reg;        // serial shift-in
    logic [mhbp_pkg::DATA_W-1:0]     sout_reg;       // serial shift-out
    logic                            hdr_done_reg;   // direction and address complete
    logic                            frame_done_reg; // whole frame complete

    wire par_start = (mode_strobe && !cs_n && (rd_fall || wr_fall)) || (mode_cs && cs_fall);
    wire par_rd    = mode_strobe ? rd_fall : filt[mhbp_pkg::IDX_WR];
    wire par_end   = mode_strobe ? (dir_rd_reg ? rd_rise : wr_rise) : cs_rise;
    wire hold_done = (hold_cnt_reg == ACK_W'(mhbp_pkg::ACK_MIN_CYC));
    wire ser_act   = mode_serial && !cs_n;
    wire out_edge  = filt[mhbp_pkg::IDX_EDGE] ? sck_fall : sck_rise;
    wire out_slot  = (bit_cnt_reg >= CNT_W'(mhbp_pkg::HDR_BITS)) &&
                     (bit_cnt_reg < CNT_W'(mhbp_pkg::FRAME_BITS));

    // the extra wait clock also lets read data come back before ready moves
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            st_reg       <= mhbp_pkg::ST_IDLE;
            dir_rd_reg   <= 1'b0;
            hold_cnt_reg <= '0;
        end else begin
            case (st_reg)
                mhbp_pkg::ST_IDLE: begin
                    hold_cnt_reg <= '0;
                    if (par_start) begin
                        st_reg     <= mhbp_pkg::ST_WAIT;
                        dir_rd_reg <= par_rd;
                    end
                end
                mhbp_pkg::ST_WAIT: begin
                    if (cs_n) begin
                        st_reg <= mhbp_pkg::ST_IDLE;
                    end else if (hold_done) begin
                        st_reg <= mhbp_pkg::ST_DONE;
                    end else begin
                        hold_cnt_reg <= hold_cnt_reg + 1'b1;
                    end
                end
                mhbp_pkg::ST_DONE: begin
                    if (par_end || cs_n) begin
                        st_reg <= mhbp_pkg::ST_IDLE;
                    end
                end
                default: begin
                    st_reg <= mhbp_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ready pin: strobe style idles high and dips; chip-select style idles high and acknowledges low
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            ready_out      <= 1'b1;
            ready_oe_n_out <= 1'b1;
        end else begin
            ready_oe_n_out <= !((mode_strobe || mode_cs) && !cs_n);
            if (st_reg == mhbp_pkg::ST_IDLE && par_start) begin
                ready_out <= !mode_strobe;
            end else if (st_reg == mhbp_pkg::ST_WAIT && !cs_n && hold_done) begin
                ready_out <= mode_strobe;
            end else if (st_reg != mhbp_pkg::ST_IDLE && (cs_n || (st_reg == mhbp_pkg::ST_DONE && par_end))) begin
                ready_out <= 1'b1;
            end
        end
    end

    // register requests, read data and data bus enables
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            req_out       <= '0;
            rd_pend_reg   <= 1'b0;
            sout_reg      <= '0;
            data_out      <= '0;
            data_oe_n_out <= '1;
        end else begin
            req_out.rd  <= 1'b0;
            req_out.wr  <= 1'b0;
            rd_pend_reg <= req_out.rd;
            if (st_reg == mhbp_pkg::ST_IDLE && par_start) begin
                // the address is held steady for the whole access, so it is taken raw
                req_out.addr <= addr_in;
                req_out.rd   <= par_rd;
            end
            if (st_reg == mhbp_pkg::ST_DONE && par_end && !dir_rd_reg) begin
                req_out.wdata <= dpipe_reg[mhbp_pkg::DATA_PIPE-1];
                req_out.wr    <= 1'b1;
            end
            if (hdr_done_reg && sin_reg[mhbp_pkg::HDR_BITS-1] == mhbp_pkg::RW_READ) begin
                req_out.addr <= sin_reg[mhbp_pkg::ADDR_W-1:0];
                req_out.rd   <= 1'b1;
            end
            if (frame_done_reg && sin_reg[mhbp_pkg::FRAME_BITS-1] != mhbp_pkg::RW_READ) begin
                req_out.addr  <= sin_reg[mhbp_pkg::DATA_W +: mhbp_pkg::ADDR_W];
                req_out.wdata <= sin_reg[mhbp_pkg::DATA_W-1:0];
                req_out.wr    <= 1'b1;
            end
            if (mode_serial) begin
                data_oe_n_out <= {{(mhbp_pkg::DATA_W-1){1'b1}}, cs_n};
                if (rd_pend_reg) begin
                    sout_reg <= rdata_in;
                end else if (ser_act && out_edge && out_slot) begin
                    data_out <= {{(mhbp_pkg::DATA_W-1){1'b0}}, sout_reg[mhbp_pkg::DATA_W-1]};
                    sout_reg <= {sout_reg[mhbp_pkg::DATA_W-2:0], 1'b0};
                end
            end else if (rd_pend_reg && !cs_n) begin
                data_out      <= rdata_in;
                data_oe_n_out <= '0;
            end else if (cs_n || (mode_strobe && rd_rise)) begin
                data_oe_n_out <= '1;
            end
        end
    end

    // serial receiver; the count restarts whenever the port is deselected
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            bit_cnt_reg    <= '0;
            sin_reg        <= '0;
            hdr_done_reg   <= 1'b0;
            frame_done_reg <= 1'b0;
        end else begin
            hdr_done_reg   <= ser_act && sck_rise && (bit_cnt_reg == CNT_W'(mhbp_pkg::HDR_BITS - 1));
            frame_done_reg <= ser_act && sck_rise && (bit_cnt_reg == CNT_W'(mhbp_pkg::FRAME_BITS - 1));
            if (!ser_act) begin
                bit_cnt_reg <= '0;
                sin_reg     <= '0;
            end else if (sck_rise) begin
                sin_reg <= {sin_reg[mhbp_pkg::FRAME_BITS-2:0], filt[mhbp_pkg::IDX_SDI]};
                if (bit_cnt_reg != CNT_W'(mhbp_pkg::FRAME_BITS)) begin
                    bit_cnt_reg <= bit_cnt_reg + 1'b1;
                end
            end
        end
    end
endmodule

/* mhbp_regs_model.sv */
// register space that answers the host port's requests
`timescale 1ns/10ps
module mhbp_regs_model (
    input  wire logic          sys_clk_in, // system clock
    input  mhbp_pkg::mhbp_req_s req_in,    // access request
    output logic [7:0]         rdata_out   // read data, cycle after rd
);
    logic [7:0] mem [32];
    always_ff @(posedge sys_clk_in) begin
        if (req_in.wr) mem[req_in.addr] <= req_in.wdata;
        // idle value keeps toggling so stale data never looks valid
        rdata_out <= req_in.rd ? mem[req_in.addr] : ~rdata_out;
    end
endmodule

/* mhbp_assertions.sv */
// pin protocol assertions for the multimode host bus port
`timescale 1ns/10ps
module mhbp_assertions (
    input wire logic           sys_clk_in,          // clock
    input wire logic           rst_n_in,            // reset
    input wire logic [2:0]     host_port_select_in, // mode
    input wire logic           chip_select_n_in,    // select
    input wire logic           read_strobe_n_in,    // read strobe
    input wire logic           write_strobe_n_in,   // write strobe
    input wire logic [7:0]     data_oe_n_out,       // bus enable
    input wire logic           ready_out,           // ready
    input wire logic           ready_oe_n_out,      // ready enable
    input mhbp_pkg::mhbp_req_s req_out              // request
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);
    wire cs = host_port_select_in == mhbp_pkg::SEL_CS_TIMED;
    wire se = host_port_select_in == mhbp_pkg::SEL_SERIAL;
    wire ss = !cs && !se;
    a_ready_low_hold: assert property ($fell(ready_out) && ss && !ready_oe_n_out |=> !ready_out)
        else $error("ready low for under two clocks");
    a_ack_high_hold: assert property ($fell(ready_out) && cs |-> $past(ready_out, 2) && !$past(chip_select_n_in, 2))
        else $error("acknowledge high for under two clocks");
    a_ready_release: assert property ($rose(chip_select_n_in) && !se |-> ##[1:8] ready_oe_n_out)
        else $error("ready not released after deselect");
    a_strobe_float: assert property ($rose(read_strobe_n_in) && ss |-> ##[1:8] &data_oe_n_out)
        else $error("bus not floated after read strobe");
    a_cs_float: assert property ($rose(chip_select_n_in) && cs |-> ##[1:8] &data_oe_n_out)
        else $error("bus not floated after deselect");
    a_sdo_release: assert property ($rose(chip_select_n_in) && se |-> ##[1:12] data_oe_n_out[0])
        else $error("serial output not released in time");
    a_serial_pins: assert property (se |-> &data_oe_n_out[7:1] && ready_oe_n_out)
        else $error("unused pin driven in serial mode");
    a_strobe_capture: assert property ($rose(req_out.wr) && ss |-> write_strobe_n_in)
        else $error("write issued before strobe rose");
    a_cs_capture: assert property ($rose(req_out.wr) && cs |-> chip_select_n_in)
        else $error("write issued before deselect");
endmodule
bind mhbp_top mhbp_assertions mhbp_assertions_inst (.sys_clk_in, .rst_n_in, .host_port_select_in, .chip_select_n_in,
    .read_strobe_n_in, .write_strobe_n_in, .data_oe_n_out, .ready_out, .ready_oe_n_out, .req_out);

/* mhbp_top_tb.sv */
// self-checking bench for the multimode host bus port
`timescale 1ns/10ps
module mhbp_top_tb;
    logic       sys_clk_in = 0, rst_n_in = 0, cs_n = 1, rd_n = 1, wr_n = 1, le = 0, rdy, rdy_oe_n;
    logic [2:0] sel = 3'h1;
    logic [4:0] addr = '0;
    logic [7:0] din = '0, dout, oe_n, rdata, q;
    int         err_total = 0, tests_run = 0, cyc = 0;
    mhbp_pkg::mhbp_req_s req;
    mhbp_top mhbp_top_inst (.sys_clk_in, .rst_n_in, .host_port_select_in(sel), .chip_select_n_in(cs_n),
        .read_strobe_n_in(rd_n), .write_strobe_n_in(wr_n), .latch_enable_in(le), .addr_in(addr),
        .data_in((dout & ~oe_n) | (din & oe_n)), .data_out(dout), .data_oe_n_out(oe_n), .ready_out(rdy),
        .ready_oe_n_out(rdy_oe_n), .req_out(req), .rdata_in(rdata));
    mhbp_regs_model mhbp_regs_model_inst (.sys_clk_in, .req_in(req), .rdata_out(rdata));
    initial forever #5 sys_clk_in = ~sys_clk_in;
    always @(posedge sys_clk_in) begin
        cyc++;
        if (cyc > 20000) begin
            err_total++;
            conclude();
        end
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wait_rdy(input logic lvl);
        int n;
        n = 0;
        while (!(rdy_oe_n === 1'b0 && rdy === lvl) && n < 40) begin
            @(posedge sys_clk_in);
            n++;
        end
        check({7'h0, n < 40}, 8'h01);
    endtask
    // the port style is a strap taken after reset, so every style change goes through reset
    task automatic restart(input logic [2:0] m);
        rst_n_in <= 1'b0;
        sel      <= m;
        repeat (6) @(posedge sys_clk_in);
        rst_n_in <= 1'b1;
        repeat (2) @(posedge sys_clk_in);
        check({oe_n[7:1], rdy_oe_n}, 8'hff);
        repeat (2) @(posedge sys_clk_in);
    endtask
    task automatic par(input logic cs_style, input logic w, input logic [4:0] a, input logic [7:0] d);
        addr <= a;
        din  <= w ? d : ~d;
        wr_n <= cs_style ? !w : 1'b1;
        @(posedge sys_clk_in);
        cs_n <= 1'b0;
        if (!cs_style) begin
            wr_n <= !w;
            rd_n <= w;
        end
        wait_rdy(cs_style);
        wait_rdy(1'b0);
        if (!cs_style) wait_rdy(1'b1);
        if (!w) check(dout | oe_n, d);
        cs_n <= 1'b1;
        rd_n <= 1'b1;
        if (!cs_style) wr_n <= 1'b1;
        @(posedge sys_clk_in);
        wr_n <= 1'b1;
        repeat (11) @(posedge sys_clk_in);
        check({oe_n[7:1], rdy_oe_n}, 8'hff);
    endtask
    task automatic ser(input logic e, input logic w, input logic [4:0] a, input logic [7:0] d);
        logic [13:0] f;
        f = {w ? ~mhbp_pkg::RW_READ : mhbp_pkg::RW_READ, a, d};
        addr <= {3'h0, e, 1'b0};
        cs_n <= 1'b0;
        repeat (8) @(posedge sys_clk_in);
        for (int i = 13; i >= 0; i--) begin
            addr[0] <= f[i];
            repeat (8) @(posedge sys_clk_in);
            if (e && i < 8) q[i] = dout[0];
            le <= 1'b1;
            repeat (8) @(posedge sys_clk_in);
            if (!e && i < 8) q[i] = dout[0];
            le <= 1'b0;
        end
        repeat (4) @(posedge sys_clk_in);
        cs_n <= 1'b1;
        repeat (30) @(posedge sys_clk_in);
        check({7'h0, oe_n[0]}, 8'h01);
    endtask
    task automatic t_strobe();
        par(1'b0, 1, 5'h03, 8'ha5);
        par(1'b0, 0, 5'h03, 8'ha5);
        $display("strobe test done");
    endtask
    task automatic t_cs();
        restart(mhbp_pkg::SEL_CS_TIMED);
        par(1'b1, 1, 5'h1f, 8'h5a);
        par(1'b1, 0, 5'h1f, 8'h5a);
        par(1'b1, 0, 5'h03, 8'ha5);
        $display("chip select test done");
    endtask
    task automatic t_serial();
        restart(mhbp_pkg::SEL_SERIAL);
        for (int e = 0; e < 2; e++) begin
            ser(e[0], 1, 5'h11, 8'hc3 ^ e[7:0]);
            ser(e[0], 0, 5'h11, 8'h00);
            check(q, 8'hc3 ^ e[7:0]);
        end
        ser(1'b0, 0, 5'h1f, 8'h00);
        check(q, 8'h5a);
        $display("serial test done");
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge sys_clk_in);
        rst_n_in <= 1;
        repeat (4) @(posedge sys_clk_in);
        t_strobe();
        t_cs();
        t_serial();
        conclude();
    end
endmodule
